// ==== inc/dps_pkg.sv ====
// Shared constants for both ends of the ddr psram link
// Functional notes
// R1 - Zero-latency write data follows command immediately
// R2 - Device drives strobes through command phase
// R3 - Device may release strobes in zero-latency write
// R4 - Host never drives strobes in zero-latency write
// R5 - Zero-latency writes ignore byte mask
// R6 - Read latency: clock runs, data released, strobes low
// R7 - Write latency: strobes released, ownership turns round
// R8 - Host drives data and strobes in write
// R9 - Device drives data and toggles strobes on reads
// R10 - Host parks clock low, complement high
// R11 - Stopped clock: owned lines hold their levels
// R12 - Host toggles clock in every transfer state
// R13 - Required lines stable for whole state
// R14 - Pending refresh: strobes high demand extra latency
// R15 - Chip select high: standby, inputs ignored
// R16 - Stop clock only low; respect select time
// R17 - Host drives command words, then releases data
package dps_pkg;
  localparam int DQ_W        = 16;
  localparam int SM_W        = 2;
  localparam int CA_EDGES    = 2;
  localparam int LAT_EDGES   = 4;
  localparam int HALF_CYC    = 8;
  localparam int CLK_NS      = 25;
  localparam int TCSM_NS     = 4000;
  localparam int TCSM_CYC    = TCSM_NS / CLK_NS;
  localparam int CS_HIGH_CYC = 4;
  localparam int CMD_RD_BIT  = 15;
  localparam int CMD_ZL_BIT  = 14;

  typedef enum logic [2:0] {
    DPS_IDLE = 3'h0,
    DPS_CA   = 3'h1,
    DPS_LAT  = 3'h2,
    DPS_XFER = 3'h3,
    DPS_END  = 3'h4
  } dps_host_st_e;
endpackage : dps_pkg

// ==== inc/dps_if.sv ====
// Link between host controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface dps_if;
  import dps_pkg::*;
  logic            cs_n;
  logic            ck_t;
  logic            ck_c;
  logic [DQ_W-1:0] h_dq_o;
  logic            h_dq_oe;
  logic [SM_W-1:0] h_sm_o;
  logic            h_sm_oe;
  logic [DQ_W-1:0] d_dq_o;
  logic            d_dq_oe;
  logic [SM_W-1:0] d_sm_o;
  logic            d_sm_oe;
  logic [DQ_W-1:0] dq;
  logic [SM_W-1:0] sm;

  // Undriven lines read low; a bench may model float separately
  assign dq = d_dq_oe ? d_dq_o : (h_dq_oe ? h_dq_o : '0);
  assign sm = d_sm_oe ? d_sm_o : (h_sm_oe ? h_sm_o : '0);

  modport host (output cs_n, ck_t, ck_c, h_dq_o, h_dq_oe, h_sm_o, h_sm_oe, input dq, sm);
  modport dev (input cs_n, ck_t, ck_c, dq, sm, output d_dq_o, d_dq_oe, d_sm_o, d_sm_oe);
endinterface : dps_if
`default_nettype wire

// ==== logic/dps_dev.sv ====
// Memory device end: bus state and line ownership
`timescale 1ns/1ps
`default_nettype none
module dps_dev
  import dps_pkg::*;
#(
  parameter int LAT = LAT_EDGES
)
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  dps_if.dev                   bus,
  input  wire logic            refresh_busy,
  output logic                 rd_req,
  output logic [DQ_W-1:0]      rd_addr,
  input  wire logic [DQ_W-1:0] rd_data,
  output logic                 wr_valid,
  output logic [DQ_W-1:0]      wr_addr,
  output logic [DQ_W-1:0]      wr_data,
  output logic [SM_W-1:0]      wr_mask
);
  if (LAT < 1 || LAT > 60) $error("dps_dev: LAT out of range");

  logic            ck_s1_q, ck_s2_q, ck_p_q, cs_s1_q, cs_s2_q, cs_p_q;
  logic [DQ_W-1:0] dq_s1_q, dq_s2_q, dq_p_q;
  logic [SM_W-1:0] sm_s1_q, sm_s2_q, sm_p_q;
  logic [7:0]      ecnt_q;
  logic [7:0]      lat_end;
  logic            rd_q, zl_q, ext_q, tog_q, ld_q, tg_pend_q, dq_oe_q;
  logic [DQ_W-1:0] addr_q, dq_q;
  logic            sel, edge_ev, data_ev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_p_q  <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_p_q  <= 1'b1;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_p_q  <= '0;
      sm_s1_q <= '0;
      sm_s2_q <= '0;
      sm_p_q  <= '0;
    end
    else if (ce)
    begin
      ck_s1_q <= bus.ck_t;
      ck_s2_q <= ck_s1_q;
      ck_p_q  <= ck_s2_q;
      cs_s1_q <= bus.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_p_q  <= cs_s2_q;
      dq_s1_q <= bus.dq;
      dq_s2_q <= dq_s1_q;
      dq_p_q  <= dq_s2_q;
      sm_s1_q <= bus.sm;
      sm_s2_q <= sm_s1_q;
      sm_p_q  <= sm_s2_q;
    end
  end

  // Lines as they stood before each edge: the host launches a word with an edge,
  // and the edge that raises select must still count
  assign sel     = !cs_p_q;
  assign edge_ev = ce && sel && (ck_s2_q != ck_p_q);
  assign lat_end = zl_q ? 8'(CA_EDGES) : (ext_q ? 8'(CA_EDGES + 2 * LAT) : 8'(CA_EDGES + LAT));
  assign data_ev = edge_ev && (ecnt_q >= lat_end);

  // Transaction tracking; deselect clears the edge count and reloads the refresh flag, rd_q, zl_q and addr_q hold
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ecnt_q <= '0;
      rd_q   <= 1'b0;
      zl_q   <= 1'b0;
      ext_q  <= 1'b0;
      addr_q <= '0;
    end
    else if (ce)
    begin
      if (!sel)
      begin
        ecnt_q <= '0; // see R15
        ext_q  <= refresh_busy; // see R14
      end
      else if (edge_ev)
      begin
        if (ecnt_q != 8'hff)
          ecnt_q <= ecnt_q + 8'h01;
        if (ecnt_q == 8'h00)
        begin
          rd_q <= dq_p_q[CMD_RD_BIT];
          zl_q <= dq_p_q[CMD_ZL_BIT] && !dq_p_q[CMD_RD_BIT];
        end
        if (ecnt_q == 8'h01)
          addr_q <= dq_p_q;
        if (data_ev)
          addr_q <= addr_q + 16'h0001;
      end
    end
  end

  // User side strobes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_req   <= 1'b0;
      rd_addr  <= '0;
      wr_valid <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_mask  <= '0;
    end
    else if (ce)
    begin
      rd_req   <= data_ev && rd_q;
      wr_valid <= data_ev && !rd_q;
      if (data_ev)
      begin
        rd_addr <= addr_q;
        wr_addr <= addr_q;
        wr_data <= dq_p_q;
        wr_mask <= zl_q ? '0 : sm_p_q; // see R5
      end
    end
  end

  // Read output: word first, strobe toggles a cycle later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ld_q      <= 1'b0;
      tg_pend_q <= 1'b0;
      tog_q     <= 1'b0;
      dq_q      <= '0;
      dq_oe_q   <= 1'b0;
    end
    else if (ce)
    begin
      // Fetched word is valid only the cycle after the request
      ld_q      <= rd_req;
      tg_pend_q <= ld_q;
      if (!sel)
      begin
        tog_q   <= 1'b0;
        dq_oe_q <= 1'b0;
      end
      else
      begin
        if (ld_q)
        begin
          dq_q    <= rd_data; // see R9
          dq_oe_q <= 1'b1;
        end
        if (tg_pend_q)
          tog_q <= !tog_q; // see R9
      end
    end
  end

  // Held registers keep lines steady while the clock is parked
  assign bus.d_dq_o  = dq_q; // see R11
  assign bus.d_dq_oe = sel && dq_oe_q; // see R6
  // Strobes: latency flag in command phase, low then toggling on reads
  assign bus.d_sm_oe = sel && ((ecnt_q < 8'(CA_EDGES)) || rd_q); // see R2 R3 R7 R13
  assign bus.d_sm_o  = (ecnt_q < 8'(CA_EDGES)) ? {SM_W{ext_q}} : {SM_W{tog_q}}; // see R6 R14
endmodule : dps_dev
`default_nettype wire

// ==== logic/dps_host.sv ====
// Host controller end with data buffers and clock generation
`timescale 1ns/1ps
`default_nettype none
module dps_fifo2
  import dps_pkg::*;
#(
  parameter int W = DQ_W
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [1:0]        count
);
  logic [W-1:0] mem_q [2];
  logic         wp_q, rp_q, push, pop;
  logic [1:0]   cnt_q;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rp_q];
  assign count     = cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= !wp_q;
      end
      if (pop)
        rp_q <= !rp_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule : dps_fifo2

module dps_host
  import dps_pkg::*;
#(
  parameter int HALF = HALF_CYC,
  parameter int LAT  = LAT_EDGES,
  parameter int TCSM = TCSM_CYC
)
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  dps_if.host                  bus,
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  wire logic            cmd_read,
  input  wire logic            cmd_zero_lat,
  input  wire logic [DQ_W-1:0] cmd_addr,
  input  wire logic [7:0]      cmd_pairs,
  input  wire logic            wr_valid,
  output logic                 wr_ready,
  input  wire logic [DQ_W-1:0] wr_data,
  output logic                 rd_valid,
  input  wire logic            rd_ready,
  output logic [DQ_W-1:0]      rd_data,
  output logic                 done,
  output logic                 cut
);
  if (HALF < 8 || HALF > 255) $error("dps_host: HALF must be 8..255");
  if (LAT < 1 || LAT > 60) $error("dps_host: LAT out of range");
  if (TCSM <= 8 * HALF || TCSM > 65535) $error("dps_host: TCSM too small or large");

  localparam logic [15:0] TCSM_LIM = 16'(TCSM - 2 * HALF);

  dps_host_st_e    st_q;
  logic [7:0]      half_q, ecnt_q, lat_q, end_q;
  logic [8:0]      left_q;
  logic [15:0]     csl_q;
  logic            ck_q, rd_q, zl_q, await_q;
  logic [DQ_W-1:0] addr_q, dq_q;
  logic            dq_oe_q, sm_oe_q;
  logic [DQ_W-1:0] dq_s1_q, dq_s2_q;
  logic [SM_W-1:0] sm_s1_q, sm_s2_q;
  logic            sm_p_q;
  logic            active, tick, go, stop_now, edge_ev, pop_w, cap;
  logic [1:0]      wf_cnt, rf_cnt;
  logic [DQ_W-1:0] wf_data;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      sm_s1_q <= '0;
      sm_s2_q <= '0;
      sm_p_q  <= 1'b0;
    end
    else if (ce)
    begin
      dq_s1_q <= bus.dq;
      dq_s2_q <= dq_s1_q;
      sm_s1_q <= bus.sm;
      sm_s2_q <= sm_s1_q;
      sm_p_q  <= sm_s2_q[0];
    end
  end

  assign active = (st_q == DPS_CA) || (st_q == DPS_LAT) || (st_q == DPS_XFER);
  assign tick   = (half_q == 8'(HALF - 1));

  // Long pauses are only taken with the clock low; a read waits for its data in either phase
  always_comb
  begin
    go = 1'b1;
    if (st_q == DPS_XFER)
    begin
      if (rd_q)
        go = !await_q && (left_q != 9'h000) && (ck_q || (rf_cnt == 2'h0)); // see R10 R16
      else if (ck_q)
        go = (left_q == 9'h001) || (wf_cnt != 2'h0);
      else
        go = (wf_cnt == 2'h2) || ((left_q == 9'h002) && (wf_cnt != 2'h0)); // see R16
    end
  end

  assign stop_now = active && tick && !ck_q && (csl_q >= TCSM_LIM); // see R16
  assign edge_ev  = ce && active && tick && go && !stop_now; // see R12
  assign cap      = (st_q == DPS_XFER) && rd_q && await_q && (sm_s2_q[0] != sm_p_q);
  assign pop_w    = edge_ev && !rd_q && (((st_q == DPS_CA) && (ecnt_q == 8'h01) && zl_q)
                    || ((st_q == DPS_LAT) && (ecnt_q == lat_q - 8'h01))
                    || ((st_q == DPS_XFER) && (left_q != 9'h001)));

  // Clock divider; a stalled tick waits for the go condition
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      half_q <= '0;
      ck_q   <= 1'b0;
    end
    else if (ce)
    begin
      if (!active)
      begin
        half_q <= '0;
        ck_q   <= 1'b0; // see R10
      end
      else if (!tick)
        half_q <= half_q + 8'h01;
      else if (edge_ev)
      begin
        half_q <= '0;
        ck_q   <= !ck_q;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      csl_q <= '0;
    else if (ce)
      csl_q <= active ? csl_q + 16'h0001 : 16'h0000;
  end

  assign cmd_ready = (st_q == DPS_IDLE) && (cmd_read || (wf_cnt == 2'h2));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q    <= DPS_IDLE;
      ecnt_q  <= '0;
      lat_q   <= '0;
      end_q   <= '0;
      left_q  <= '0;
      rd_q    <= 1'b0;
      zl_q    <= 1'b0;
      await_q <= 1'b0;
      addr_q  <= '0;
      dq_q    <= '0;
      dq_oe_q <= 1'b0;
      sm_oe_q <= 1'b0;
      done    <= 1'b0;
      cut     <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (stop_now || (cap && (left_q == 9'h000)))
      begin
        st_q    <= DPS_END;
        cut     <= stop_now;
        done    <= 1'b1;
        dq_oe_q <= 1'b0;
        sm_oe_q <= 1'b0;
        end_q   <= '0;
        await_q <= 1'b0;
      end
      else
      begin
        if (cap)
          await_q <= 1'b0;
        unique case (st_q)
          DPS_IDLE:
            if (cmd_valid && cmd_ready && (cmd_pairs != 8'h00))
            begin
              rd_q    <= cmd_read;
              zl_q    <= cmd_zero_lat && !cmd_read;
              addr_q  <= cmd_addr;
              left_q  <= {cmd_pairs, 1'b0};
              dq_q    <= {cmd_read, cmd_zero_lat && !cmd_read, 14'h0000}; // see R17
              dq_oe_q <= 1'b1;
              ecnt_q  <= '0;
              cut     <= 1'b0;
              st_q    <= DPS_CA;
            end
          DPS_CA:
            if (edge_ev)
            begin
              ecnt_q <= ecnt_q + 8'h01;
              if (ecnt_q == 8'h00)
                dq_q <= addr_q;
              else
              begin
                ecnt_q <= '0;
                lat_q  <= sm_s2_q[0] ? 8'(2 * LAT) : 8'(LAT); // see R14
                if (zl_q)
                begin
                  st_q <= DPS_XFER; // see R1 R4
                  dq_q <= wf_data;
                end
                else
                begin
                  st_q    <= DPS_LAT;
                  dq_oe_q <= 1'b0; // see R6 R17
                end
              end
            end
          DPS_LAT:
            if (edge_ev)
            begin
              ecnt_q <= ecnt_q + 8'h01;
              if (ecnt_q == lat_q - 8'h01)
              begin
                st_q <= DPS_XFER;
                if (!rd_q)
                begin
                  dq_q    <= wf_data; // see R8
                  dq_oe_q <= 1'b1;
                  sm_oe_q <= 1'b1; // see R7 R8
                end
              end
            end
          DPS_XFER:
            if (edge_ev)
            begin
              left_q <= left_q - 9'h001;
              if (rd_q)
                await_q <= 1'b1;
              else if (left_q == 9'h001)
              begin
                st_q    <= DPS_END;
                done    <= 1'b1;
                dq_oe_q <= 1'b0;
                sm_oe_q <= 1'b0;
                end_q   <= '0;
              end
              else
                dq_q <= wf_data; // see R13
            end
          DPS_END:
          begin
            end_q <= end_q + 8'h01;
            if (end_q == 8'(CS_HIGH_CYC - 1))
              st_q <= DPS_IDLE;
          end
          default:
            st_q <= DPS_IDLE;
        endcase
      end
    end
  end

  dps_fifo2 #(.W(DQ_W)) u_wbuf (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (),
    .out_ready (pop_w),
    .out_data  (wf_data),
    .count     (wf_cnt)
  );

  // Room for a word pair is checked before each rising edge
  dps_fifo2 #(.W(DQ_W)) u_rbuf (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (cap),
    .in_ready  (),
    .in_data   (dq_s2_q),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .count     (rf_cnt)
  );

  assign bus.cs_n    = !active;
  assign bus.ck_t    = ck_q;
  assign bus.ck_c    = !ck_q; // see R10
  assign bus.h_dq_o  = dq_q;
  assign bus.h_dq_oe = dq_oe_q;
  assign bus.h_sm_o  = '0; // see R8
  assign bus.h_sm_oe = sm_oe_q && !zl_q; // see R4
endmodule : dps_host
`default_nettype wire

// ==== verif/dps_link_asserts.sv ====
// Bus ownership checks on the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module dps_link_asserts
  import dps_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            cs_n,
  input wire logic            ck_t,
  input wire logic            ck_c,
  input wire logic            h_dq_oe,
  input wire logic            h_sm_oe,
  input wire logic            d_dq_oe,
  input wire logic            d_sm_oe,
  input wire logic [SM_W-1:0] d_sm_o,
  input wire logic [DQ_W-1:0] dq,
  input wire logic [SM_W-1:0] sm
);
  logic [7:0] ec_q;
  logic       ck_prev_q;
  logic       cs_prev_q;
  logic       rd_q;
  logic       zl_q;
  logic       ext_q;
  logic [7:0] hi_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Link clock edges since select fell
  always_ff @(posedge clk)
  begin
    ck_prev_q <= ck_t;
    hi_q      <= ck_t ? hi_q + 8'h01 : 8'h00;
    if (rst || cs_n)
      ec_q <= 8'h00;
    else if (ck_t != ck_prev_q)
      ec_q <= ec_q + 8'h01;
  end

  // Transfer kind from the first command word; strobe level late in command phase
  always_ff @(posedge clk)
  begin
    cs_prev_q <= cs_n;
    if (!cs_n && cs_prev_q)
    begin
      rd_q  <= dq[CMD_RD_BIT];
      zl_q  <= dq[CMD_ZL_BIT] & ~dq[CMD_RD_BIT];
      ext_q <= 1'b0;
    end
    else if (ec_q == 8'h01)
      ext_q <= (sm == 2'b11);
  end

  // Count held a while so the device's synchroniser delay has passed
  sequence s_settled(bit c, logic [7:0] n);
    c && ec_q == n && $past(ec_q, 4) == n;
  endsequence

  sequence s_data(bit c);
    c && !cs_n && ec_q >= (ext_q ? 8'h0c : 8'h08);
  endsequence

  a_no_contention: assert property (!(h_dq_oe && d_dq_oe) && !(h_sm_oe && d_sm_oe))
    else $error("both ends drive one line");
  a_clock_pair: assert property (ck_c == ~ck_t)
    else $error("clock complement wrong");
  a_clock_parked: assert property (cs_n |-> !ck_t)
    else $error("clock high while deselected");
  a_ca_toggles: assert property (!cs_n && ec_q == 8'h01 |-> ##[1:9] $changed(ck_t))
    else $error("clock stalled in command phase");
  a_ca_strobe_own: assert property (!cs_n && ec_q == 8'h01 |-> d_sm_oe)
    else $error("strobes undriven in command phase");
  a_rd_lat_turn: assert property (s_settled(rd_q, 8'h03) |-> d_sm_oe && d_sm_o == 2'b00 && !d_dq_oe && !h_dq_oe)
    else $error("read latency ownership wrong");
  a_wr_lat_turn: assert property (s_settled(!rd_q && !zl_q, 8'h03) |-> !d_sm_oe && !h_sm_oe && !h_dq_oe)
    else $error("write latency ownership wrong");
  a_ext_lat_wait: assert property (s_settled(rd_q && ext_q, 8'h07) |-> !d_dq_oe && d_sm_o == 2'b00)
    else $error("extended latency not kept");
  a_zl_data_next: assert property (zl_q && !cs_n && ec_q == 8'h02 |-> h_dq_oe)
    else $error("zero latency data late");
  a_zl_host_quiet: assert property (!cs_n && zl_q |-> !h_sm_oe)
    else $error("host drove strobes in zero latency write");
  a_zl_dev_low: assert property (zl_q && ec_q >= 8'h03 && d_sm_oe |-> d_sm_o == 2'b00)
    else $error("device strobes not low");
  a_rd_data_own: assert property (s_data(rd_q) |-> d_dq_oe && d_sm_oe)
    else $error("device not driving read data");
  a_wr_data_own: assert property (s_data(!rd_q && !zl_q) |-> h_dq_oe && h_sm_oe)
    else $error("host not driving write data");
  a_dev_standby: assert property (cs_n [*5] |-> !d_dq_oe && !d_sm_oe)
    else $error("device drives while deselected");
  // A read may stretch the high phase by two cycles, never park it there
  a_high_bounded: assert property (hi_q <= 8'h0c)
    else $error("clock held high");
endmodule : dps_link_asserts
`default_nettype wire

// ==== verif/tb_ddr_psram_bus_state_ownership.sv ====
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_psram_bus_state_ownership
  import dps_pkg::*;
;
  logic            clk;
  logic            rst;
  logic            refresh_busy;
  logic            cmd_valid;
  logic            cmd_ready;
  logic            cmd_read;
  logic            cmd_zero_lat;
  logic [DQ_W-1:0] cmd_addr;
  logic [7:0]      cmd_pairs;
  logic            h_wr_valid;
  logic            h_wr_ready;
  logic [DQ_W-1:0] h_wr_data;
  logic            h_rd_valid;
  logic            h_rd_ready;
  logic [DQ_W-1:0] h_rd_data;
  logic            done;
  logic            cut;
  logic            d_rd_req;
  logic [DQ_W-1:0] d_rd_addr;
  logic [DQ_W-1:0] d_rd_data;
  logic            d_wr_valid;
  logic [DQ_W-1:0] d_wr_addr;
  logic [DQ_W-1:0] d_wr_data;
  logic [SM_W-1:0] d_wr_mask;
  int              err_count;
  int              samples_checked;
  logic [DQ_W-1:0] mem[logic [DQ_W-1:0]];
  logic [DQ_W-1:0] wq[$];
  logic [DQ_W-1:0] rd_exp[$];
  logic [DQ_W-1:0] ra_exp[$];
  logic [33:0]     wr_exp[$];

  dps_if link ();

  // Select limit raised so long read stalls never cut a transfer
  dps_host #(.TCSM(1000)) i_dps_host (.clk(clk), .rst(rst), .ce(1'b1), .bus(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_zero_lat(cmd_zero_lat), .cmd_addr(cmd_addr),
    .cmd_pairs(cmd_pairs), .wr_valid(h_wr_valid), .wr_ready(h_wr_ready), .wr_data(h_wr_data),
    .rd_valid(h_rd_valid), .rd_ready(h_rd_ready), .rd_data(h_rd_data), .done(done), .cut(cut));
  dps_dev i_dps_dev (.clk(clk), .rst(rst), .ce(1'b1), .bus(link), .refresh_busy(refresh_busy),
    .rd_req(d_rd_req), .rd_addr(d_rd_addr), .rd_data(d_rd_data), .wr_valid(d_wr_valid),
    .wr_addr(d_wr_addr), .wr_data(d_wr_data), .wr_mask(d_wr_mask));
  dps_link_asserts i_dps_link_asserts (.clk(clk), .rst(rst), .cs_n(link.cs_n), .ck_t(link.ck_t),
    .ck_c(link.ck_c), .h_dq_oe(link.h_dq_oe), .h_sm_oe(link.h_sm_oe), .d_dq_oe(link.d_dq_oe),
    .d_sm_oe(link.d_sm_oe), .d_sm_o(link.d_sm_o), .dq(link.dq), .sm(link.sm));

  always #12.5 clk = ~clk;

  // Unwritten words read back as a pattern of their address
  function automatic logic [DQ_W-1:0] peek(input logic [DQ_W-1:0] a);
    return mem.exists(a) ? mem[a] : (a ^ 16'ha5c3);
  endfunction : peek

  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      chk("wait length", 34'(lim - 1), 34'(n));
      complete_run();
    end
  endtask : bound

  // Memory side of the device, user side of the host, write feeder
  always @(posedge clk)
  begin
    if (d_rd_req === 1'b1)
    begin
      d_rd_data <= peek(d_rd_addr);
      chk("fetch address", {18'h0, ra_exp.size() ? ra_exp.pop_front() : 16'hxxxx}, {18'h0, d_rd_addr});
    end
    if (d_wr_valid === 1'b1)
      chk("stored word", wr_exp.size() ? wr_exp.pop_front() : 34'hx, {d_wr_mask, d_wr_addr, d_wr_data});
    if (h_rd_valid === 1'b1 && h_rd_ready === 1'b1)
      chk("read word", {18'h0, rd_exp.size() ? rd_exp.pop_front() : 16'hxxxx}, {18'h0, h_rd_data});
    h_rd_ready <= ($urandom_range(3) != 0);
    if (h_wr_valid === 1'b1 && h_wr_ready === 1'b1)
      void'(wq.pop_front());
    // Sparse write words make the host stall with its clock low
    if (h_wr_valid !== 1'b1 || h_wr_ready === 1'b1)
      h_wr_valid <= (wq.size() != 0) && ($urandom_range(5) == 0);
    h_wr_data  <= wq.size() ? wq[0] : 16'h0000;
  end

  task automatic txn(input logic rd, input logic zl, input logic busy, input int pairs);
    logic [DQ_W-1:0] a;
    logic [DQ_W-1:0] w;
    int              n;
    a = 16'($urandom_range(63));
    for (int i = 0; i < 2 * pairs; i++)
    begin
      w = 16'($urandom);
      if (rd)
      begin
        rd_exp.push_back(peek(a + 16'(i)));
        ra_exp.push_back(a + 16'(i));
      end
      else
      begin
        mem[a + 16'(i)] = w;
        wq.push_back(w);
        wr_exp.push_back({2'b00, a + 16'(i), w});
      end
    end
    @(posedge clk);
    refresh_busy <= busy;
    cmd_read     <= rd;
    cmd_zero_lat <= zl;
    cmd_addr     <= a;
    cmd_pairs    <= 8'(pairs);
    cmd_valid    <= 1'b1;
    @(negedge clk);
    for (n = 0; n < 500 && cmd_ready !== 1'b1; n++)
      @(negedge clk);
    bound(n, 500);
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 4000 && done !== 1'b1; n++)
      @(negedge clk);
    bound(n, 4000);
    for (n = 0; n < 400 && (rd_exp.size() || ra_exp.size() || wr_exp.size()); n++)
      @(negedge clk);
    bound(n, 400);
    chk("select limit", 34'h0, {33'h0, cut});
    chk("idle lines", 34'h2, {32'h0, link.cs_n, link.ck_t});
  endtask : txn

  initial
  begin
    void'($urandom(28));
    clk             = 1'b0;
    rst             = 1'b1;
    refresh_busy    = 1'b0;
    cmd_valid       = 1'b0;
    cmd_read        = 1'b0;
    cmd_zero_lat    = 1'b0;
    cmd_addr        = 16'h0000;
    cmd_pairs       = 8'h00;
    h_wr_valid      = 1'b0;
    h_wr_data       = 16'h0000;
    h_rd_ready      = 1'b0;
    d_rd_data       = 16'h0000;
    err_count       = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    txn(1'b0, 1'b0, 1'b0, 2);
    txn(1'b1, 1'b0, 1'b0, 2);
    txn(1'b0, 1'b1, 1'b0, 3);
    txn(1'b0, 1'b1, 1'b1, 1);
    txn(1'b1, 1'b0, 1'b1, 3);
    txn(1'b0, 1'b0, 1'b1, 2);
    // Mixed traffic with read stalls parking the clock
    for (int k = 0; k < 12; k++)
      txn(1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)), $urandom_range(6, 1));
    complete_run();
  end
endmodule : tb_ddr_psram_bus_state_ownership
`default_nettype wire
